// ==== verilog/prs_pkg.sv ====
/*
 * Constants, encodings and state type for the radio power-mode and
 * reset sequencer.
 * Assumes a 250 MHz core clock from the crystal oscillator path.
 */
package prs_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS    = 4;
    localparam int unsigned OFF_TO_IDLE_MS   = 25;
    localparam int unsigned OFF_TO_IDLE_CYC  =
        OFF_TO_IDLE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned OFF_CNT_W        = 23;
    localparam logic [3:0]  CLKO_HALF_CYC    = 4'h2;
    localparam logic [7:0]  ENTRY_CLKO_CYC   = 8'h80;
    localparam logic [7:0]  DOZE_CLKO_CYC    = 8'h80;

    // ------------------------------------------------------------
    // Serial header layout
    // ------------------------------------------------------------
    localparam logic [3:0]  HDR_BITS         = 4'h8;
    localparam int unsigned HDR_RW_POS       = 7;
    localparam logic [5:0]  SOFT_RESET_ADDR  = 6'h00;
    localparam logic        HDR_WRITE        = 1'b0;

    // ------------------------------------------------------------
    // Radio sequence select encoding
    // ------------------------------------------------------------
    localparam logic [1:0]  SEQ_IDLE         = 2'h0;
    localparam logic [1:0]  SEQ_CCA          = 2'h1;
    localparam logic [1:0]  SEQ_RX           = 2'h2;
    localparam logic [1:0]  SEQ_TX           = 2'h3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [23:0] TIMER_RST        = 24'h000000;
    localparam logic [7:0]  CNT8_RST         = 8'h00;

    // ------------------------------------------------------------
    // Power modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PRS_OFF,
        PRS_IDLE,
        PRS_ACTIVE,
        PRS_ENTER_HIB,
        PRS_HIB,
        PRS_ENTER_DOZE,
        PRS_DOZE,
        PRS_DOZE_NOTMR
    } prs_mode_t;

endpackage : prs_pkg

// ==== verilog/prs_sequencer.sv ====
/*
 * Power-mode and reset sequencer of the transceiver digital core:
 * serial-header software reset, Off/Hibernate/Doze/timerless Doze,
 * wake paths back to Idle, clock output gating and the sleep-wake flag.
 * Assumes the core clock keeps running for the always-on wake logic,
 * and that control bits come from a register file on the same clock.
 */
`timescale 1ns/10ps

// Operation
// - Header write to address zero resets core
// - Soft reset like pin reset, RAM kept
// - Reset asserts right after eighth header bit
// - Soft reset holds until chip enable high
// - Read of address zero does nothing
// - Reset pin low: Off, tri-state, RAM lost
// - Reach Idle within 25 ms of release
// - Sequence select starts radio; bits start sleep
// - Sequence codes: 00 idle ... 11 transmit
// - Low start gate holds device in Idle
// - Hibernate stops SPI, timers, oscillator; retains
// - Deep sleep bit: Hibernate after 128 cycles
// - Keep 128 clock-output cycles before stopping
// - Hibernate exit only by wake or reset
// - Doze keeps oscillator and timer, SPI off
// - Light sleep bit: Doze after 128 cycles
// - Clock out in Doze optional, else stops
// - Timer compare ends Doze, sets wake flag
// - Wake interrupt only when enabled
// - Clock restarts after Doze, except low rates
// - Wake or reset pin ends Doze anytime
// - Armed compare still flags after pin wake
// - Timerless Doze stops timer, keeps clock out
// - Timerless sleep bit enters timerless Doze
module prs_sequencer #(
    parameter int unsigned OFF_TO_IDLE_CYCLES = prs_pkg::OFF_TO_IDLE_CYC
) (
    // Core clock and power-on reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Host pins
    input  wire logic        reset_pin_n,
    input  wire logic        wake_request_pin_n,
    input  wire logic        radio_start_gate,
    input  wire logic        spi_ce_n,
    input  wire logic        spi_sck,
    input  wire logic        spi_mosi,
    // Control bits from the register file
    input  wire logic [1:0]  seq_select,
    input  wire logic        light_sleep_req,
    input  wire logic        deep_sleep_req,
    input  wire logic        timerless_sleep_req,
    input  wire logic        clko_in_sleep_en,
    input  wire logic        clko_enable,
    input  wire logic        clko_rate_low,
    input  wire logic        wake_timer_en,
    input  wire logic [23:0] wake_compare_value,
    input  wire logic        wake_irq_en,
    input  wire logic        wake_flag_clear,
    input  wire logic        seq_done,
    // Pins driven out
    output logic             clko,
    output logic             clko_oe_n,
    output logic             irq_n,
    output logic             irq_oe_n,
    // Core status and controls
    output prs_pkg::prs_mode_t mode,
    output logic             core_reset,
    output logic             ram_clear,
    output logic             spi_enable,
    output logic             osc_run,
    output logic             timer_run,
    output logic [1:0]       active_seq,
    output logic             sleep_wake_flag
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        prs_pkg::prs_mode_t mode;
        logic        rstp_s1;
        logic        rstp_s2;
        logic        wake_s1;
        logic        wake_s2;
        logic        gate_s1;
        logic        gate_s2;
        logic        ce_s1;
        logic        ce_s2;
        logic        sck_s1;
        logic        sck_s2;
        logic        sck_d;
        logic        mosi_s1;
        logic        mosi_s2;
        logic [7:0]  hdr;
        logic [3:0]  hdr_cnt;
        logic        hdr_done;
        logic        soft_rst;
        logic [prs_pkg::OFF_CNT_W-1:0] off_cnt;
        logic [3:0]  clko_div;
        logic        clko_int;
        logic        clko_hold;
        logic [7:0]  entry_cnt;
        logic [7:0]  doze_cnt;
        logic [23:0] timer;
        logic        wake_flag;
        logic        clko;
        logic        clko_oe_n;
        logic        irq_n;
        logic        irq_oe_n;
        logic        core_reset;
        logic        ram_clear;
        logic        spi_enable;
        logic        osc_run;
        logic        timer_run;
        logic [1:0]  active_seq;
    } prs_state_t;

    localparam logic [prs_pkg::OFF_CNT_W-1:0] OFF_LAST =
        prs_pkg::OFF_CNT_W'(OFF_TO_IDLE_CYCLES - 1);

    prs_state_t r;
    prs_state_t next_r;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic hw_off;
        logic sck_rise;
        logic clko_tick;
        logic spi_live;
        logic match;
        logic tmr_on;
        logic clk_on;
        logic doze_exit;
        logic [7:0] hdr_n;
        hw_off    = 1'b0;
        sck_rise  = 1'b0;
        clko_tick = 1'b0;
        spi_live  = 1'b0;
        match     = 1'b0;
        tmr_on    = 1'b0;
        clk_on    = 1'b0;
        doze_exit = 1'b0;
        hdr_n     = r.hdr;
        next_r    = r;

        next_r.rstp_s1 = reset_pin_n;
        next_r.rstp_s2 = r.rstp_s1;
        next_r.wake_s1 = wake_request_pin_n;
        next_r.wake_s2 = r.wake_s1;
        next_r.gate_s1 = radio_start_gate;
        next_r.gate_s2 = r.gate_s1;
        next_r.ce_s1   = spi_ce_n;
        next_r.ce_s2   = r.ce_s1;
        next_r.sck_s1  = spi_sck;
        next_r.sck_s2  = r.sck_s1;
        next_r.sck_d   = r.sck_s2;
        next_r.mosi_s1 = spi_mosi;
        next_r.mosi_s2 = r.mosi_s1;

        hw_off   = !r.rstp_s2;
        sck_rise = r.sck_s2 && !r.sck_d;

        // Clock-output divider; stopped with the oscillator
        // oscillator off in Hibernate
        if (r.mode != prs_pkg::PRS_HIB && r.mode != prs_pkg::PRS_OFF) begin
            if (r.clko_div == prs_pkg::CLKO_HALF_CYC - 4'h1) begin
                next_r.clko_div = 4'h0;
                next_r.clko_int = !r.clko_int;
                clko_tick       = !r.clko_int;
            end else begin
                next_r.clko_div = r.clko_div + 4'h1;
            end
        end

        // Event timer and wake compare
        // timer frozen in timerless Doze
        tmr_on = wake_timer_en && r.mode != prs_pkg::PRS_OFF
              && r.mode != prs_pkg::PRS_HIB
              && r.mode != prs_pkg::PRS_DOZE_NOTMR;
        if (tmr_on) begin
            next_r.timer = r.timer + 24'h000001;
        end
        // armed compare flags in any mode but Off, Hibernate and timerless Doze
        match = tmr_on && r.timer == wake_compare_value;
        next_r.wake_flag = match || (r.wake_flag && !wake_flag_clear);

        // Serial header watch for software reset
        // serial port dead while asleep
        spi_live = r.mode == prs_pkg::PRS_IDLE
                || r.mode == prs_pkg::PRS_ACTIVE;
        if (r.ce_s2) begin
            next_r.hdr_cnt  = 4'h0;
            next_r.hdr_done = 1'b0;
            next_r.soft_rst = 1'b0;
        end else if (spi_live && sck_rise && !r.hdr_done) begin
            hdr_n          = {r.hdr[6:0], r.mosi_s2};
            next_r.hdr     = hdr_n;
            next_r.hdr_cnt = r.hdr_cnt + 4'h1;
            if (r.hdr_cnt == prs_pkg::HDR_BITS - 4'h1) begin
                next_r.hdr_done = 1'b1;
                if (hdr_n[prs_pkg::HDR_RW_POS] == prs_pkg::HDR_WRITE
                    && hdr_n[5:0] == prs_pkg::SOFT_RESET_ADDR) begin
                    next_r.soft_rst = 1'b1;
                end
            end
        end

        // low-rate clock stays off until enable toggles
        if (!clko_enable) begin
            next_r.clko_hold = 1'b0;
        end

        // Mode sequencing
        unique case (r.mode)
            prs_pkg::PRS_OFF: begin
                if (r.off_cnt == OFF_LAST) begin
                    next_r.mode = prs_pkg::PRS_IDLE;
                end else begin
                    next_r.off_cnt = r.off_cnt + 1'b1;
                end
            end
            prs_pkg::PRS_IDLE: begin
                next_r.entry_cnt = prs_pkg::CNT8_RST;
                if (deep_sleep_req) begin
                    next_r.mode = prs_pkg::PRS_ENTER_HIB;
                end else if (light_sleep_req || timerless_sleep_req) begin
                    next_r.mode = prs_pkg::PRS_ENTER_DOZE;
                end else if (seq_select != prs_pkg::SEQ_IDLE
                             && r.gate_s2) begin
                    next_r.mode       = prs_pkg::PRS_ACTIVE;
                    next_r.active_seq = seq_select;
                end
            end
            prs_pkg::PRS_ACTIVE: begin
                // abort on gate low or idle code
                if (!r.gate_s2 || seq_select == prs_pkg::SEQ_IDLE
                    || seq_done) begin
                    next_r.mode       = prs_pkg::PRS_IDLE;
                    next_r.active_seq = prs_pkg::SEQ_IDLE;
                end
            end
            prs_pkg::PRS_ENTER_HIB, prs_pkg::PRS_ENTER_DOZE: begin
                if (clko_tick) begin
                    next_r.entry_cnt = r.entry_cnt + 8'h01;
                    if (r.entry_cnt == prs_pkg::ENTRY_CLKO_CYC - 8'h01) begin
                        next_r.doze_cnt = prs_pkg::CNT8_RST;
                        if (r.mode == prs_pkg::PRS_ENTER_HIB) begin
                            next_r.mode = prs_pkg::PRS_HIB;
                        end else if (timerless_sleep_req) begin
                            next_r.mode = prs_pkg::PRS_DOZE_NOTMR;
                        end else begin
                            next_r.mode = prs_pkg::PRS_DOZE;
                        end
                    end
                end
            end
            prs_pkg::PRS_HIB: begin
                if (!r.wake_s2) begin
                    next_r.mode = prs_pkg::PRS_IDLE;
                end
            end
            prs_pkg::PRS_DOZE: begin
                if (clko_tick && r.doze_cnt != prs_pkg::DOZE_CLKO_CYC) begin
                    next_r.doze_cnt = r.doze_cnt + 8'h01;
                end
                // compare or wake pin ends Doze
                doze_exit = match || !r.wake_s2;
            end
            prs_pkg::PRS_DOZE_NOTMR: begin
                // only the wake or reset pin ends it
                if (!r.wake_s2) begin
                    next_r.mode = prs_pkg::PRS_IDLE;
                end
            end
        endcase

        if (doze_exit) begin
            next_r.mode = prs_pkg::PRS_IDLE;
            // low rates need enable cleared and set
            if (r.doze_cnt == prs_pkg::DOZE_CLKO_CYC && !clko_in_sleep_en
                && clko_rate_low) begin
                next_r.clko_hold = 1'b1;
            end
        end

        if (r.soft_rst) begin
            next_r.mode       = prs_pkg::PRS_IDLE;
            next_r.timer      = prs_pkg::TIMER_RST;
            next_r.wake_flag  = 1'b0;
            next_r.clko_hold  = 1'b0;
            next_r.active_seq = prs_pkg::SEQ_IDLE;
        end

        if (hw_off) begin
            next_r.mode       = prs_pkg::PRS_OFF;
            next_r.off_cnt    = '0;
            next_r.timer      = prs_pkg::TIMER_RST;
            next_r.wake_flag  = 1'b0;
            next_r.clko_hold  = 1'b0;
            next_r.soft_rst   = 1'b0;
            next_r.active_seq = prs_pkg::SEQ_IDLE;
        end

        // Registered outputs from the next mode
        unique case (next_r.mode)
            prs_pkg::PRS_IDLE, prs_pkg::PRS_ACTIVE,
            prs_pkg::PRS_ENTER_HIB, prs_pkg::PRS_ENTER_DOZE,
            prs_pkg::PRS_DOZE_NOTMR: begin
                clk_on = 1'b1;
            end
            prs_pkg::PRS_DOZE: begin
                clk_on = clko_in_sleep_en
                      || next_r.doze_cnt != prs_pkg::DOZE_CLKO_CYC;
            end
            prs_pkg::PRS_OFF, prs_pkg::PRS_HIB: begin
                clk_on = 1'b0;
            end
        endcase
        next_r.clko       = next_r.clko_int && clk_on && clko_enable
                         && !next_r.clko_hold;
        next_r.clko_oe_n  = next_r.mode == prs_pkg::PRS_OFF;
        next_r.irq_oe_n   = next_r.mode == prs_pkg::PRS_OFF;
        next_r.irq_n      = !(next_r.wake_flag && wake_irq_en);
        next_r.core_reset = next_r.soft_rst
                         || next_r.mode == prs_pkg::PRS_OFF;
        next_r.ram_clear  = next_r.mode == prs_pkg::PRS_OFF;
        next_r.spi_enable = next_r.mode == prs_pkg::PRS_IDLE
                         || next_r.mode == prs_pkg::PRS_ACTIVE;
        next_r.osc_run    = next_r.mode != prs_pkg::PRS_OFF
                         && next_r.mode != prs_pkg::PRS_HIB;
        next_r.timer_run  = wake_timer_en
                         && next_r.mode != prs_pkg::PRS_OFF
                         && next_r.mode != prs_pkg::PRS_HIB
                         && next_r.mode != prs_pkg::PRS_DOZE_NOTMR;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            r            <= '0;
            r.mode       <= prs_pkg::PRS_OFF;
            r.wake_s1    <= 1'b1;
            r.wake_s2    <= 1'b1;
            r.ce_s1      <= 1'b1;
            r.ce_s2      <= 1'b1;
            r.clko_oe_n  <= 1'b1;
            r.irq_n      <= 1'b1;
            r.irq_oe_n   <= 1'b1;
            r.core_reset <= 1'b1;
            r.ram_clear  <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign clko            = r.clko;
    assign clko_oe_n       = r.clko_oe_n;
    assign irq_n           = r.irq_n;
    assign irq_oe_n        = r.irq_oe_n;
    assign mode            = r.mode;
    assign core_reset      = r.core_reset;
    assign ram_clear       = r.ram_clear;
    assign spi_enable      = r.spi_enable;
    assign osc_run         = r.osc_run;
    assign timer_run       = r.timer_run;
    assign active_seq      = r.active_seq;
    assign sleep_wake_flag = r.wake_flag;

endmodule : prs_sequencer

// ==== tb/prs_host.sv ====
/* Host model driving the serial pins and the wake pin.
   Assumes the core clock; pins change 1 ns after its rising edge. */
`timescale 1ns/10ps
module prs_host (
    // Clock
    input  logic clock,
    // Pins to the device
    output logic spi_ce_n,
    output logic spi_sck,
    output logic spi_mosi,
    output logic wake_request_pin_n
);
    initial begin
        spi_ce_n           = 1'b1;
        spi_sck            = 1'b0;
        spi_mosi           = 1'b0;
        wake_request_pin_n = 1'b1;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step
    // Header MSB first; sck held four clocks in each phase
    task automatic send_hdr(input logic [7:0] h);
        spi_ce_n = 1'b0;
        step(4);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi = h[i];
            step(4);
            spi_sck = 1'b1;
            step(4);
            spi_sck = 1'b0;
        end
        step(4);
    endtask : send_hdr
    // Released data line shows the inverse of its last bit
    task automatic end_frame();
        spi_ce_n = 1'b1;
        spi_mosi = ~spi_mosi;
        step(1);
    endtask : end_frame
    task automatic wake_pulse();
        wake_request_pin_n = 1'b0;
        step(6);
        wake_request_pin_n = 1'b1;
        step(1);
    endtask : wake_pulse
endmodule : prs_host

// ==== tb/prs_sequencer_asserts.sv ====
/* Port checker of the sequencer, bound to every instance.
   Assumes one clock domain and the synchronous active-high rst. */
`timescale 1ns/10ps
module prs_sequencer_asserts (
    // Clock and reset
    input logic               clock,
    input logic               rst,
    // Watched inputs
    input logic               radio_start_gate,
    input logic               spi_ce_n,
    input logic               wake_irq_en,
    // Watched outputs
    input logic               clko,
    input logic               clko_oe_n,
    input logic               irq_n,
    input logic               irq_oe_n,
    input prs_pkg::prs_mode_t mode,
    input logic               core_reset,
    input logic               ram_clear,
    input logic               spi_enable,
    input logic               osc_run,
    input logic               timer_run,
    input logic [1:0]         active_seq
);
    logic [9:0] entry_cnt;
    // Cycles spent in a sleep entry state
    always_ff @(posedge clock) begin
        if (rst) begin
            entry_cnt <= 10'h000;
        end else if (mode == prs_pkg::PRS_ENTER_HIB ||
                     mode == prs_pkg::PRS_ENTER_DOZE) begin
            entry_cnt <= entry_cnt + 10'h001;
        end else begin
            entry_cnt <= 10'h000;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_off_release: assert property (mode == prs_pkg::PRS_OFF |->
        clko_oe_n && irq_oe_n && ram_clear && core_reset)
        else $error("pins driven or memory kept in off mode");
    a_idle_ram: assert property (mode == prs_pkg::PRS_IDLE |->
        !ram_clear && !clko_oe_n && !irq_oe_n)
        else $error("memory cleared or pins released in idle");
    a_sleep_no_spi: assert property (mode inside {prs_pkg::PRS_HIB,
        prs_pkg::PRS_DOZE, prs_pkg::PRS_DOZE_NOTMR} |-> !spi_enable)
        else $error("serial port enabled while asleep");
    a_hib_stopped: assert property (mode == prs_pkg::PRS_HIB |->
        !osc_run && !timer_run)
        else $error("oscillator or timer running in hibernate");
    a_hib_clko: assert property (mode == prs_pkg::PRS_HIB &&
        $past(mode) == prs_pkg::PRS_HIB |-> $stable(clko))
        else $error("clock output toggles in hibernate");
    a_doze_osc: assert property (mode == prs_pkg::PRS_DOZE |->
        osc_run)
        else $error("oscillator stopped in doze");
    a_notmr_timer: assert property (mode == prs_pkg::PRS_DOZE_NOTMR |->
        osc_run && !timer_run)
        else $error("timer running in timerless doze");
    a_gate_low: assert property (!radio_start_gate [*5] |->
        mode != prs_pkg::PRS_ACTIVE)
        else $error("active with start gate low");
    a_irq_masked: assert property (!wake_irq_en [*2] |-> irq_n)
        else $error("interrupt raised while disabled");
    a_soft_hold: assert property (core_reset && !spi_ce_n &&
        mode != prs_pkg::PRS_OFF |=> core_reset)
        else $error("soft reset dropped with chip enable low");
    a_entry_time: assert property ((mode == prs_pkg::PRS_HIB &&
        $past(mode) == prs_pkg::PRS_ENTER_HIB) || (mode ==
        prs_pkg::PRS_DOZE && $past(mode) == prs_pkg::PRS_ENTER_DOZE)
        |-> entry_cnt inside {[500:520]})
        else $error("sleep entry delay off");
    a_idle_seq: assert property (mode != prs_pkg::PRS_ACTIVE |->
        active_seq == 2'h0)
        else $error("sequence code shown outside active");
endmodule : prs_sequencer_asserts
bind prs_sequencer prs_sequencer_asserts u_chk (.clock(clock), .rst(rst),
    .radio_start_gate(radio_start_gate), .spi_ce_n(spi_ce_n),
    .wake_irq_en(wake_irq_en), .clko(clko), .clko_oe_n(clko_oe_n),
    .irq_n(irq_n), .irq_oe_n(irq_oe_n), .mode(mode),
    .core_reset(core_reset), .ram_clear(ram_clear),
    .spi_enable(spi_enable), .osc_run(osc_run), .timer_run(timer_run),
    .active_seq(active_seq));

// ==== tb/radio_power_mode_sequencer_test.sv ====
/* Self-checking bench of the power-mode sequencer.
   Assumes the host model and the checker are compiled before it. */
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module radio_power_mode_sequencer_test;
    localparam int OFF_CYC = 20;
    localparam int ENTRY   = int'(prs_pkg::ENTRY_CLKO_CYC) * 2 *
                             int'(prs_pkg::CLKO_HALF_CYC);
    logic clock, rst, reset_pin_n, radio_start_gate, seq_done;
    logic spi_ce_n, spi_sck, spi_mosi, wake_request_pin_n;
    logic light_sleep_req, deep_sleep_req, timerless_sleep_req;
    logic wake_timer_en, wake_irq_en, wake_flag_clear;
    logic clko, clko_oe_n, irq_n, irq_oe_n, core_reset, ram_clear;
    logic spi_enable, osc_run, timer_run, sleep_wake_flag;
    logic [1:0]         seq_select, active_seq;
    logic [23:0]        wake_compare_value;
    prs_pkg::prs_mode_t mode;
    int                 num_errors = 0;
    int                 n_tests = 0;
    prs_host host (.clock(clock), .spi_ce_n(spi_ce_n), .spi_sck(spi_sck),
        .spi_mosi(spi_mosi), .wake_request_pin_n(wake_request_pin_n));
    prs_sequencer #(.OFF_TO_IDLE_CYCLES(OFF_CYC)) dut (.clock(clock),
        .rst(rst), .reset_pin_n(reset_pin_n),
        .wake_request_pin_n(wake_request_pin_n),
        .radio_start_gate(radio_start_gate), .spi_ce_n(spi_ce_n),
        .spi_sck(spi_sck), .spi_mosi(spi_mosi), .seq_select(seq_select),
        .light_sleep_req(light_sleep_req), .deep_sleep_req(deep_sleep_req),
        .timerless_sleep_req(timerless_sleep_req),
        .clko_in_sleep_en(1'b0), .clko_enable(1'b1), .clko_rate_low(1'b0),
        .wake_timer_en(wake_timer_en),
        .wake_compare_value(wake_compare_value), .wake_irq_en(wake_irq_en),
        .wake_flag_clear(wake_flag_clear), .seq_done(seq_done),
        .clko(clko), .clko_oe_n(clko_oe_n), .irq_n(irq_n),
        .irq_oe_n(irq_oe_n), .mode(mode), .core_reset(core_reset),
        .ram_clear(ram_clear), .spi_enable(spi_enable), .osc_run(osc_run),
        .timer_run(timer_run), .active_seq(active_seq),
        .sleep_wake_flag(sleep_wake_flag));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    // Wait for a mode, counting cycles and clock output rises
    task automatic wait_mode(input prs_pkg::prs_mode_t m, input int lim,
                             output int n, output int r);
        logic prev;
        n = 0;
        r = 0;
        prev = clko;
        while (mode !== m && n < lim) begin
            tick(1);
            n++;
            if (clko === 1'b1 && prev === 1'b0) r++;
            prev = clko;
        end
        `CHK(mode, m)
        if (mode !== m) complete_run();
    endtask : wait_mode
    task automatic soft_reset();
        host.send_hdr(8'h00);
        `CHK(core_reset, 1'b1)
        tick(20);
        `CHK(core_reset, 1'b1)
        host.end_frame();
        tick(8);
        `CHK({core_reset, ram_clear}, 2'h0)
        `CHK(mode, prs_pkg::PRS_IDLE)
    endtask : soft_reset
    task automatic doze_run(input bit by_pin);
        int n, r;
        wake_timer_en = 1'b0;
        soft_reset();
        `CHK(sleep_wake_flag, 1'b0)
        wake_compare_value = 24'(1500 + $urandom_range(63, 0));
        wake_timer_en = 1'b1;
        light_sleep_req = 1'b1;
        wait_mode(prs_pkg::PRS_DOZE, ENTRY + 16, n, r);
        light_sleep_req = 1'b0;
        `CHK(n inside {[ENTRY - 8:ENTRY + 8]}, 1'b1)
        `CHK(r inside {[127:129]}, 1'b1)
        `CHK({osc_run, spi_enable}, 2'h2)
        if (by_pin) begin
            host.wake_pulse();
            wait_mode(prs_pkg::PRS_IDLE, 8, n, r);
            `CHK(sleep_wake_flag, 1'b0)
            for (n = 0; n < 2000 && sleep_wake_flag !== 1'b1; n++) tick(1);
            `CHK(sleep_wake_flag, 1'b1)
        end else begin
            tick(600);
            for (r = 0, n = 0; n < 50; n++) begin tick(1); r += clko; end
            `CHK(r, 0)
            wait_mode(prs_pkg::PRS_IDLE, 1000, n, r);
            `CHK({sleep_wake_flag, irq_n}, 2'h2)
            for (r = 0, n = 0; n < 20; n++) begin tick(1); r += clko; end
            `CHK(r > 0, 1'b1)
            wake_flag_clear = 1'b1;
            tick(1);
            wake_flag_clear = 1'b0;
            tick(2);
            `CHK({sleep_wake_flag, irq_n}, 2'h1)
        end
    endtask : doze_run
    initial begin
        int n, r;
        rst = 1'b1;
        reset_pin_n = 1'b0;
        {radio_start_gate, seq_done, seq_select} = 4'h0;
        {light_sleep_req, deep_sleep_req, timerless_sleep_req} = 3'h0;
        {wake_timer_en, wake_irq_en, wake_flag_clear} = 3'h2;
        wake_compare_value = 24'h000000;
        void'($urandom(32'h499f5d3f));
        tick(5);
        rst = 1'b0;
        tick(3);
        `CHK(mode, prs_pkg::PRS_OFF)
        `CHK({clko_oe_n, irq_oe_n, ram_clear}, 3'h7)
        reset_pin_n = 1'b1;
        wait_mode(prs_pkg::PRS_IDLE, OFF_CYC + 10, n, r);
        `CHK({n >= OFF_CYC, spi_enable}, 2'h3)
        for (int c = 1; c < 4; c++) begin
            seq_select = 2'(c);
            tick(6);
            `CHK(mode, prs_pkg::PRS_IDLE)
            radio_start_gate = 1'b1;
            tick(6);
            `CHK({mode, active_seq}, {prs_pkg::PRS_ACTIVE, 2'(c)})
            seq_done = 1'b1;
            seq_select = prs_pkg::SEQ_IDLE;
            tick(1);
            seq_done = 1'b0;
            radio_start_gate = 1'b0;
            tick(6);
            `CHK(mode, prs_pkg::PRS_IDLE)
        end
        for (int i = 0; i < 2; i++) begin
            host.send_hdr(i == 0 ? 8'h80 : {2'h0, 6'($urandom_range(63, 1))});
            tick(8);
            `CHK(core_reset, 1'b0)
            host.end_frame();
        end
        deep_sleep_req = 1'b1;
        wait_mode(prs_pkg::PRS_HIB, ENTRY + 16, n, r);
        deep_sleep_req = 1'b0;
        `CHK(n inside {[ENTRY - 8:ENTRY + 8]}, 1'b1)
        `CHK(r inside {[127:129]}, 1'b1)
        host.send_hdr(8'h00);
        `CHK({core_reset, mode}, {1'b0, prs_pkg::PRS_HIB})
        host.end_frame();
        host.wake_pulse();
        wait_mode(prs_pkg::PRS_IDLE, 10, n, r);
        doze_run(1'b1);
        doze_run(1'b0);
        timerless_sleep_req = 1'b1;
        wait_mode(prs_pkg::PRS_DOZE_NOTMR, ENTRY + 16, n, r);
        timerless_sleep_req = 1'b0;
        `CHK({timer_run, osc_run}, 2'h1)
        for (r = 0, n = 0; n < 40; n++) begin tick(1); r += clko; end
        `CHK({r > 0, mode}, {1'b1, prs_pkg::PRS_DOZE_NOTMR})
        reset_pin_n = 1'b0;
        wait_mode(prs_pkg::PRS_OFF, 8, n, r);
        `CHK(irq_oe_n, 1'b1)
        reset_pin_n = 1'b1;
        wait_mode(prs_pkg::PRS_IDLE, OFF_CYC + 10, n, r);
        complete_run();
    end
endmodule : radio_power_mode_sequencer_test
